/* logic/dual_timers_pkg.sv */
// Constants, field layouts and codes of the dual period timers
package dual_timers_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int REG_W = 8;
    localparam int IDX_W = 6;
    localparam int PRE_W = 6;
    localparam int SCAL_W = 5;
    localparam int SYNC_STAGES = 3;
    typedef logic [IDX_W-1:0] reg_idx_t;
    // Register indices; byte address is four times the index
    localparam reg_idx_t IDX_T1_BOUND = 6'h09;
    localparam reg_idx_t IDX_T1_DIV = 6'h17;
    localparam reg_idx_t IDX_T1_CTRL = 6'h1C;
    localparam reg_idx_t IDX_T1_COUNT = 6'h1D;
    localparam reg_idx_t IDX_T2_CTRL = 6'h32;
    localparam reg_idx_t IDX_T2_COUNT = 6'h33;
    localparam reg_idx_t IDX_T2_DIV = 6'h34;
    localparam reg_idx_t IDX_T2_BOUND = 6'h35;
    localparam logic [REG_W-1:0] REG_RESET = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Field positions
    localparam int T1_SRC_LSB = 4;
    localparam int T1_SRC_W = 4;
    localparam int T1_OUT_LSB = 2;
    localparam int INV_BIT = 0;
    localparam int T2_SRC_LSB = 4;
    localparam int T2_SRC_W = 3;
    localparam int XOSC_EN_BIT = 0;
    localparam int PRE_LSB = 5;
    localparam int T1_SCAL_LSB = 0;
    localparam int T2_SCAL_LSB = 0;
    localparam logic [REG_W-1:0] T1_CTRL_MASK = 8'hFF;
    localparam logic [REG_W-1:0] T2_CTRL_MASK = 8'h71;
    localparam logic [REG_W-1:0] DIV_MASK = 8'h7F;
    // Timer one clock sources
    localparam logic [3:0] T1_SRC_SYS = 4'h1;
    localparam logic [3:0] T1_SRC_FAST = 4'h2;
    localparam logic [3:0] T1_SRC_SLOW = 4'h4;
    localparam logic [3:0] T1_SRC_CMP = 4'h5;
    localparam logic [3:0] T1_SRC_PA0_RISE = 4'h8;
    localparam logic [3:0] T1_SRC_PA0_FALL = 4'h9;
    localparam logic [3:0] T1_SRC_PA4_RISE = 4'hC;
    localparam logic [3:0] T1_SRC_PA4_FALL = 4'hD;
    // Timer two clock sources
    localparam logic [2:0] T2_SRC_SYS = 3'h1;
    localparam logic [2:0] T2_SRC_FAST = 3'h2;
    localparam logic [2:0] T2_SRC_SLOW = 3'h4;
    localparam logic [2:0] T2_SRC_CMP = 3'h5;
    localparam logic [2:0] T2_SRC_XSLOW = 3'h6;
    // Output routing
    localparam logic [1:0] OUT_PA3 = 2'h2;
    localparam logic [1:0] OUT_PA4 = 2'h3;
    // Synchronised input lanes
    localparam int LANE_FAST = 0;
    localparam int LANE_SLOW = 1;
    localparam int LANE_XSLOW = 2;
    localparam int LANE_CMP = 3;
    localparam int LANE_PA0 = 4;
    localparam int LANE_PA4 = 5;
    localparam int LANES = 6;
    // Prescaler terminal counts for divide by 1, 4, 16, 64
    localparam logic [PRE_W-1:0] PRE_MAX_1 = 6'h00;
    localparam logic [PRE_W-1:0] PRE_MAX_4 = 6'h03;
    localparam logic [PRE_W-1:0] PRE_MAX_16 = 6'h0F;
    localparam logic [PRE_W-1:0] PRE_MAX_64 = 6'h3F;
    localparam logic [SCAL_W-1:0] SCAL_MAX_1 = 5'h00;
    localparam logic [SCAL_W-1:0] SCAL_MAX_2 = 5'h01;
    localparam logic [SCAL_W-1:0] SCAL_MAX_4 = 5'h03;
    function automatic logic [PRE_W-1:0] pre_max(input logic [1:0] code);
        case (code)
            2'h0: pre_max = PRE_MAX_1;
            2'h1: pre_max = PRE_MAX_4;
            2'h2: pre_max = PRE_MAX_16;
            default: pre_max = PRE_MAX_64;
        endcase
    endfunction
endpackage

/* logic/timer_link_if.sv */
// Control and status carried between the register block and one timer
interface timer_link_if #(
    parameter int PRE_W = 6,
    parameter int SCAL_W = 5,
    parameter int CNT_W = 8
);
    logic tick;
    logic [PRE_W-1:0] pre_max;
    logic [SCAL_W-1:0] scal_max;
    logic [CNT_W-1:0] bound;
    logic load;
    logic [CNT_W-1:0] load_value;
    logic [CNT_W-1:0] count;
    logic wave;
    modport ctrl (
        output tick, pre_max, scal_max, bound, load, load_value,
        input count, wave
    );
    modport tmr (
        input tick, pre_max, scal_max, bound, load, load_value,
        output count, wave
    );
endinterface

/* logic/period_timer.sv */
// One period-mode timer with prescaler and scalar
module period_timer (
    input wire logic aclk,
    input wire logic aresetn,
    timer_link_if.tmr link
);
    import dual_timers_pkg::*;

    logic [PRE_W-1:0] pre_q;
    logic [SCAL_W-1:0] scal_q;
    logic [REG_W-1:0] count_q;
    logic wave_q;
    logic pre_done;
    logic scal_done;
    logic at_bound;

    // Compare with >= so a lowered limit never strands a counter
    assign pre_done = link.tick && (pre_q >= link.pre_max);
    assign scal_done = pre_done && (scal_q >= link.scal_max);
    assign at_bound = scal_done && (count_q >= link.bound);
    assign link.count = count_q;
    assign link.wave = wave_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pre_q <= '0;
            scal_q <= '0;
        end else if (link.tick) begin
            pre_q <= pre_done ? '0 : pre_q + 1'b1;
            if (pre_done) begin
                scal_q <= scal_done ? '0 : scal_q + 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_q <= REG_RESET;
            wave_q <= 1'b0;
        end else begin
            if (link.load) begin
                count_q <= link.load_value;
            end else if (at_bound) begin
                count_q <= '0;
            end else if (scal_done) begin
                count_q <= count_q + 1'b1;
            end
            if (at_bound) begin
                wave_q <= ~wave_q;
            end
        end
    end
endmodule

/* logic/edge_sync.sv */
// Three-stage synchroniser with settled-level edge pulses
module edge_sync #(
    parameter int WIDTH = 1
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] rise,
    output logic [WIDTH-1:0] fall
);
    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;
    logic [WIDTH-1:0] level_q;
    logic [WIDTH-1:0] agree;

    // Only the second and third stages are compared
    assign agree = ~(s2_q ^ s3_q);
    assign rise = agree & s3_q & ~level_q;
    assign fall = agree & ~s3_q & level_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            level_q <= '0;
        end else begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            level_q <= (agree & s3_q) | (~agree & level_q);
        end
    end
endmodule

/* logic/dual_period_timers.sv */
// Register block and clock selection of the two timers, and pin routing of timer one
module dual_period_timers (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [dual_timers_pkg::ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    input wire logic [dual_timers_pkg::DATA_W-1:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [dual_timers_pkg::ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    output logic [dual_timers_pkg::DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic fast_internal_osc,
    input wire logic slow_internal_osc,
    input wire logic extra_slow_internal_osc,
    input wire logic comparator_result,
    input wire logic port_a_bit0_in,
    input wire logic port_a_bit4_in,
    output logic extra_slow_osc_enable,
    output logic port_a_bit3_out,
    output logic port_a_bit3_oe,
    output logic port_a_bit4_out,
    output logic port_a_bit4_oe,
    output logic second_timer_wave
);
    import dual_timers_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Decode helpers

    function automatic logic idx_known(input reg_idx_t idx);
        idx_known = (idx == IDX_T1_BOUND) || (idx == IDX_T1_DIV) ||
            (idx == IDX_T1_CTRL) || (idx == IDX_T1_COUNT) ||
            (idx == IDX_T2_CTRL) || (idx == IDX_T2_COUNT) ||
            (idx == IDX_T2_DIV) || (idx == IDX_T2_BOUND);
    endfunction

    function automatic logic addr_hit(input logic [ADDR_W-1:0] addr);
        addr_hit = (addr[1:0] == 2'h0) && idx_known(addr[ADDR_W-1:2]);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Registers

    logic [REG_W-1:0] t1_ctrl_q;
    logic [REG_W-1:0] t1_div_q;
    logic [REG_W-1:0] t1_bound_q;
    logic [REG_W-1:0] t2_ctrl_q;
    logic [REG_W-1:0] t2_div_q;
    logic [REG_W-1:0] t2_bound_q;

    ////////////////////////////////////////////////////////////////////////
    // Write channel: address and data taken in either order

    logic aw_held_q;
    logic w_held_q;
    logic [ADDR_W-1:0] aw_addr_q;
    logic [REG_W-1:0] w_data_q;
    logic w_lane_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic wr_fire;
    logic wr_hit;
    logic wr_ok;
    reg_idx_t wr_idx;

    assign awready = ~aw_held_q;
    assign wready = ~w_held_q;
    assign wr_fire = aw_held_q & w_held_q & ~bvalid_q;
    assign wr_idx = aw_addr_q[ADDR_W-1:2];
    assign wr_hit = addr_hit(aw_addr_q);
    assign wr_ok = wr_fire & wr_hit & w_lane_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            aw_addr_q <= '0;
        end else if (awvalid && awready) begin
            aw_held_q <= 1'b1;
            aw_addr_q <= awaddr;
        end else if (wr_fire) begin
            aw_held_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_q <= 1'b0;
            w_data_q <= REG_RESET;
            w_lane_q <= 1'b0;
        end else if (wvalid && wready) begin
            w_held_q <= 1'b1;
            w_data_q <= wdata[REG_W-1:0];
            w_lane_q <= wstrb[0];
        end else if (wr_fire) begin
            w_held_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (bready) begin
            bvalid_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register updates

    logic wr_t1_ctrl;
    logic wr_t1_div;
    logic wr_t1_bound;
    logic wr_t2_ctrl;
    logic wr_t2_div;
    logic wr_t2_bound;
    logic wr_t2_count;

    assign wr_t1_ctrl = wr_ok && (wr_idx == IDX_T1_CTRL);
    assign wr_t1_div = wr_ok && (wr_idx == IDX_T1_DIV);
    assign wr_t1_bound = wr_ok && (wr_idx == IDX_T1_BOUND);
    assign wr_t2_ctrl = wr_ok && (wr_idx == IDX_T2_CTRL);
    assign wr_t2_div = wr_ok && (wr_idx == IDX_T2_DIV);
    assign wr_t2_bound = wr_ok && (wr_idx == IDX_T2_BOUND);
    assign wr_t2_count = wr_ok && (wr_idx == IDX_T2_COUNT);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            t1_ctrl_q <= REG_RESET;
            t1_div_q <= REG_RESET;
            t1_bound_q <= REG_RESET;
            t2_ctrl_q <= REG_RESET;
            t2_div_q <= REG_RESET;
            t2_bound_q <= REG_RESET;
        end else begin
            if (wr_t1_ctrl) begin
                t1_ctrl_q <= w_data_q & T1_CTRL_MASK;
            end
            if (wr_t1_div) begin
                t1_div_q <= w_data_q & DIV_MASK;
            end
            if (wr_t1_bound) begin
                t1_bound_q <= w_data_q;
            end
            if (wr_t2_ctrl) begin
                t2_ctrl_q <= w_data_q & T2_CTRL_MASK;
            end
            if (wr_t2_div) begin
                t2_div_q <= w_data_q & DIV_MASK;
            end
            if (wr_t2_bound) begin
                t2_bound_q <= w_data_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read channel; write-only registers read as zero

    timer_link_if #(.PRE_W(PRE_W), .SCAL_W(SCAL_W), .CNT_W(REG_W)) t1_link();
    timer_link_if #(.PRE_W(PRE_W), .SCAL_W(SCAL_W), .CNT_W(REG_W)) t2_link();

    logic rvalid_q;
    logic [REG_W-1:0] rdata_q;
    logic [1:0] rresp_q;
    reg_idx_t rd_idx;
    logic [REG_W-1:0] rd_value;

    assign rd_idx = araddr[ADDR_W-1:2];
    assign rd_value = (rd_idx == IDX_T1_CTRL) ? t1_ctrl_q :
        (rd_idx == IDX_T1_COUNT) ? t1_link.count :
        (rd_idx == IDX_T2_CTRL) ? t2_ctrl_q :
        (rd_idx == IDX_T2_COUNT) ? t2_link.count :
        REG_RESET;
    assign arready = ~rvalid_q;
    assign rvalid = rvalid_q;
    assign rresp = rresp_q;
    assign rdata = {{(DATA_W-REG_W){1'b0}}, rdata_q};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= REG_RESET;
            rresp_q <= RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid_q <= 1'b1;
            rdata_q <= addr_hit(araddr) ? rd_value : REG_RESET;
            rresp_q <= addr_hit(araddr) ? RESP_OKAY : RESP_SLVERR;
        end else if (rready) begin
            rvalid_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Clock sources from outside the clock domain

    logic [LANES-1:0] src_raw;
    logic [LANES-1:0] src_rise;
    logic [LANES-1:0] src_fall;

    assign src_raw[LANE_FAST] = fast_internal_osc;
    assign src_raw[LANE_SLOW] = slow_internal_osc;
    assign src_raw[LANE_XSLOW] = extra_slow_internal_osc;
    assign src_raw[LANE_CMP] = comparator_result;
    assign src_raw[LANE_PA0] = port_a_bit0_in;
    assign src_raw[LANE_PA4] = port_a_bit4_in;

    edge_sync #(.WIDTH(LANES)) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in(src_raw),
        .rise(src_rise),
        .fall(src_fall)
    );

    ////////////////////////////////////////////////////////////////////////
    // Clock selection; reserved codes give no clock

    logic [T1_SRC_W-1:0] t1_src;
    logic [T2_SRC_W-1:0] t2_src;
    logic xosc_on;

    assign t1_src = t1_ctrl_q[T1_SRC_LSB +: T1_SRC_W];
    assign t2_src = t2_ctrl_q[T2_SRC_LSB +: T2_SRC_W];
    assign xosc_on = t2_ctrl_q[XOSC_EN_BIT];
    assign extra_slow_osc_enable = xosc_on;

    assign t1_link.tick =
        (t1_src == T1_SRC_SYS) ||
        ((t1_src == T1_SRC_FAST) && src_rise[LANE_FAST]) ||
        ((t1_src == T1_SRC_SLOW) && src_rise[LANE_SLOW]) ||
        ((t1_src == T1_SRC_CMP) && src_rise[LANE_CMP]) ||
        ((t1_src == T1_SRC_PA0_RISE) && src_rise[LANE_PA0]) ||
        ((t1_src == T1_SRC_PA0_FALL) && src_fall[LANE_PA0]) ||
        ((t1_src == T1_SRC_PA4_RISE) && src_rise[LANE_PA4]) ||
        ((t1_src == T1_SRC_PA4_FALL) && src_fall[LANE_PA4]);

    // Extra slow oscillator only runs while enabled
    assign t2_link.tick =
        (t2_src == T2_SRC_SYS) ||
        ((t2_src == T2_SRC_FAST) && src_rise[LANE_FAST]) ||
        ((t2_src == T2_SRC_SLOW) && src_rise[LANE_SLOW]) ||
        ((t2_src == T2_SRC_CMP) && src_rise[LANE_CMP]) ||
        ((t2_src == T2_SRC_XSLOW) && xosc_on &&
            src_rise[LANE_XSLOW]);

    ////////////////////////////////////////////////////////////////////////
    // Dividers and bounds

    logic [1:0] t2_scal_code;

    assign t1_link.pre_max = pre_max(t1_div_q[PRE_LSB +: 2]);
    assign t1_link.scal_max = t1_div_q[T1_SCAL_LSB +: SCAL_W];
    assign t1_link.bound = t1_bound_q;
    assign t1_link.load = 1'b0;
    assign t1_link.load_value = REG_RESET;

    assign t2_scal_code = t2_div_q[T2_SCAL_LSB +: 2];
    assign t2_link.pre_max = pre_max(t2_div_q[PRE_LSB +: 2]);
    assign t2_link.scal_max = (t2_scal_code == 2'h1) ? SCAL_MAX_2 :
        (t2_scal_code == 2'h3) ? SCAL_MAX_4 : SCAL_MAX_1;
    assign t2_link.bound = t2_bound_q;
    assign t2_link.load = wr_t2_count;
    assign t2_link.load_value = w_data_q;

    period_timer u_t1 (
        .aclk(aclk),
        .aresetn(aresetn),
        .link(t1_link)
    );

    period_timer u_t2 (
        .aclk(aclk),
        .aresetn(aresetn),
        .link(t2_link)
    );

    ////////////////////////////////////////////////////////////////////////
    // Timer one output to pins

    logic [1:0] t1_route;
    logic t1_pin_level;

    assign t1_route = t1_ctrl_q[T1_OUT_LSB +: 2];
    assign t1_pin_level = t1_link.wave ^ t1_ctrl_q[INV_BIT];
    assign port_a_bit3_oe = (t1_route == OUT_PA3);
    assign port_a_bit4_oe = (t1_route == OUT_PA4);
    assign port_a_bit3_out = port_a_bit3_oe & t1_pin_level;
    assign port_a_bit4_out = port_a_bit4_oe & t1_pin_level;
    assign second_timer_wave = t2_link.wave;
endmodule

/* bench/dual_timers_chk.sv */
// Port checker of the dual period timers
module dual_timers_chk (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic [dual_timers_pkg::ADDR_W-1:0] araddr,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [dual_timers_pkg::DATA_W-1:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic extra_slow_osc_enable,
    input wire logic port_a_bit3_out,
    input wire logic port_a_bit3_oe,
    input wire logic port_a_bit4_out,
    input wire logic port_a_bit4_oe,
    input wire logic second_timer_wave
);
    import dual_timers_pkg::*;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire ar_take = arvalid && arready;
    wire wr_take = awvalid && awready && wvalid && wready;
    ////////////////////////////////////////////////////////////////////////
    a_pin_exclusive: assert property (
        !(port_a_bit3_oe && port_a_bit4_oe)) else $error("both pins driven");
    a_pin_gated: assert property (
        (!port_a_bit3_oe |-> !port_a_bit3_out)
        and (!port_a_bit4_oe |-> !port_a_bit4_out))
        else $error("undriven pin shows level");
    a_bresp_hold: assert property (bvalid && !bready |=>
        bvalid && $stable(bresp)) else $error("write response dropped");
    a_rdata_hold: assert property (rvalid && !rready |=> rvalid &&
        $stable(rdata) && $stable(rresp)) else $error("read data moved");
    a_read_answer: assert property (ar_take |=> rvalid)
        else $error("read not answered");
    a_write_answer: assert property (wr_take |-> ##[1:2] bvalid)
        else $error("write not answered");
    a_upper_zero: assert property (rvalid |-> rdata[31:8] == 24'h0)
        else $error("upper read bits set");
    a_wo_zero: assert property (
        ar_take && araddr inside {8'h24, 8'h5C, 8'hD0, 8'hD4} |=>
        !rdata && rresp == RESP_OKAY) else $error("write-only reads data");
    a_reset_quiet: assert property ($rose(aresetn) |->
        !bvalid && !rvalid && !extra_slow_osc_enable && !second_timer_wave
        && !port_a_bit3_oe && !port_a_bit4_oe)
        else $error("not idle after reset");
endmodule
bind dual_period_timers dual_timers_chk chk_inst (
    .aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready),
    .extra_slow_osc_enable(extra_slow_osc_enable),
    .port_a_bit3_out(port_a_bit3_out), .port_a_bit3_oe(port_a_bit3_oe),
    .port_a_bit4_out(port_a_bit4_out), .port_a_bit4_oe(port_a_bit4_oe),
    .second_timer_wave(second_timer_wave));

/* bench/port_pins_model.sv */
// Model of the external port pins feeding the edge sources
module port_pins_model (
    input wire logic aclk,
    output logic pa0_drive,
    output logic pa4_drive
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        pa0_drive = 1'b0;
        pa4_drive = 1'b0;
    end
    // Pulses wide enough for the three-flop synchroniser
    task automatic pulse(input int pin, input int n);
        repeat (n) begin
            @(posedge aclk);
            if (pin == 0) pa0_drive <= 1'b1; else pa4_drive <= 1'b1;
            repeat (5) @(posedge aclk);
            if (pin == 0) pa0_drive <= 1'b0; else pa4_drive <= 1'b0;
            repeat (5) @(posedge aclk);
        end
    endtask
endmodule

/* bench/dual_period_timers_tb.sv */
// Self-checking bench of the dual period timers
module dual_period_timers_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import dual_timers_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic fosc = 1'b0, sosc = 1'b0, xosc = 1'b0, cmp = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, xosc_en, wave2;
    logic p3_out, p3_oe, p4_out, p4_oe, pa0_drive, pa4_drive;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    int bad_count = 0, cmp_count = 0, cyc = 0;
    wire p4_in = p4_oe ? p4_out : pa4_drive;
    dual_period_timers dual_period_timers_inst (
        .aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .fast_internal_osc(fosc), .slow_internal_osc(sosc),
        .extra_slow_internal_osc(xosc), .comparator_result(cmp),
        .port_a_bit0_in(pa0_drive), .port_a_bit4_in(p4_in),
        .extra_slow_osc_enable(xosc_en), .port_a_bit3_out(p3_out),
        .port_a_bit3_oe(p3_oe), .port_a_bit4_out(p4_out),
        .port_a_bit4_oe(p4_oe), .second_timer_wave(wave2));
    port_pins_model port_pins_model_inst (.aclk(aclk), .pa0_drive(pa0_drive),
        .pa4_drive(pa4_drive));
    ////////////////////////////////////////////////////////////////////////
    always #5 aclk = ~aclk;
    // Oscillators of 8, 20, 30 and 24 cycles, off the clock edge
    initial begin #3; forever #40 fosc = ~fosc; end
    initial begin #3; forever #100 sosc = ~sosc; end
    initial begin #3; forever #150 xosc = ~xosc; end
    initial begin #3; forever #120 cmp = ~cmp; end
    task automatic stop_test();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 40000) begin
            bad_count++;
            stop_test();
        end
    end
    task automatic check(input string nm, input logic [31:0] s, e);
        cmp_count++;
        if (s !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic axi_write(input logic [7:0] a, d, output logic [1:0] r);
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
            output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, d);
        logic [1:0] r;
        axi_write(a, d, r);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        logic [1:0] r;
        axi_read(a, d, r);
    endtask
    // Cycles between the second and third toggle, -1 if none
    task automatic measure(input int sel, output int n);
        int k, c;
        logic p;
        k = 0;
        c = 0;
        p = sel == 0 ? p3_out : wave2;
        while (k < 3 && c < 800) begin
            @(posedge aclk);
            c++;
            if ((sel == 0 ? p3_out : wave2) !== p) begin
                k++;
                p = sel == 0 ? p3_out : wave2;
                if (k == 2) c = 0;
            end
        end
        n = k == 3 ? c : -1;
    endtask
    task automatic half(input logic [7:0] ca, cv, ba, bv, da, dv,
            input int sel, output int n);
        wr(ba, bv);
        wr(da, dv);
        wr(ca, cv);
        measure(sel, n);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        logic [7:0] a[8] = '{8'h74, 8'hCC, 8'h70, 8'hC8, 8'h24, 8'h5C,
            8'hD0, 8'hD4};
        logic [31:0] d;
        foreach (a[i]) begin
            rd(a[i], d);
            check("reset value", d, 32'h0);
        end
    endtask
    task automatic t_bus();
        logic [31:0] d;
        logic [1:0] r;
        wr(8'h74, 8'h33);
        rd(8'h74, d);
        check("count read-only", d, 32'h0);
        axi_read(8'h00, d, r);
        check("unmapped read", r, RESP_SLVERR);
        axi_write(8'h71, 8'h01, r);
        check("misaligned write", r, RESP_SLVERR);
    endtask
    task automatic t_regs2();
        logic [31:0] d;
        wr(8'hC8, 8'hFF);
        rd(8'hC8, d);
        check("second control", d, 32'h71);
        check("osc enable on", xosc_en, 1'b1);
        wr(8'hC8, 8'h00);
        check("osc enable off", xosc_en, 1'b0);
        wr(8'hCC, 8'h5A);
        rd(8'hCC, d);
        check("second count", d, 32'h5A);
    endtask
    task automatic t_route();
        logic p;
        wr(8'h70, 8'h08);
        p = p3_out;
        check("route bit3", {p3_oe, p4_oe}, 2'b10);
        wr(8'h70, 8'h09);
        check("inverted pin", p3_out, !p);
        wr(8'h70, 8'h0D);
        check("route bit4", {p3_oe, p4_oe, p4_out}, 3'b011);
        wr(8'h70, 8'h04);
        check("route reserved", {p3_oe, p4_oe}, 2'b00);
    endtask
    task automatic t_src1();
        logic [3:0] c[10] = '{1, 2, 4, 5, 3, 6, 7, 10, 11, 0};
        int e[10] = '{1, 8, 20, 24, -1, -1, -1, -1, -1, -1};
        int n;
        foreach (c[i]) begin
            half(8'h70, {c[i], 4'h8}, 8'h24, 8'h00, 8'h5C, 8'h00, 0, n);
            check("first source", n, e[i]);
        end
    endtask
    task automatic t_src2();
        logic [2:0] c[8] = '{1, 2, 4, 5, 6, 3, 7, 6};
        logic en[8] = '{0, 0, 0, 0, 1, 0, 0, 0};
        int e[8] = '{1, 8, 20, 24, 30, -1, -1, -1};
        int n;
        foreach (c[i]) begin
            half(8'hC8, {1'b0, c[i], 3'h0, en[i]}, 8'hD4, 8'h00, 8'hD0,
                8'h00, 2, n);
            check("second source", n, e[i]);
        end
    endtask
    task automatic t_div();
        int n;
        half(8'h70, 8'h18, 8'h24, 8'h02, 8'h5C, 8'h21, 0, n);
        check("first div 4x2", n, 24);
        half(8'h70, 8'h18, 8'h24, 8'h02, 8'h5C, 8'h60, 0, n);
        check("first div 64", n, 192);
        half(8'h70, 8'h18, 8'h24, 8'h00, 8'h5C, 8'h1F, 0, n);
        check("first scalar 31", n, 32);
        half(8'hC8, 8'h10, 8'hD4, 8'h01, 8'hD0, 8'h43, 2, n);
        check("second div 16x4", n, 128);
        half(8'hC8, 8'h10, 8'hD4, 8'h01, 8'hD0, 8'h21, 2, n);
        check("second div 4x2", n, 16);
    endtask
    task automatic t_pins();
        logic [3:0] c[4] = '{8, 9, 12, 13};
        logic [31:0] c0, c1;
        logic [7:0] dl;
        wr(8'h24, 8'hFF);
        wr(8'h5C, 8'h00);
        foreach (c[i]) begin
            wr(8'h70, {c[i], 4'h8});
            rd(8'h74, c0);
            port_pins_model_inst.pulse(i / 2, 5);
            repeat (8) @(posedge aclk);
            rd(8'h74, c1);
            dl = c1[7:0] - c0[7:0];
            check("pin edges", dl, 8'd5);
        end
    endtask
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_bus();
        t_regs2();
        t_route();
        t_src1();
        t_src2();
        t_div();
        t_pins();
        stop_test();
    end
endmodule
